// [verilog/ddr2_bank_pkg.sv]
// Shared constants and types for the bank-closing timing logic.
// Assumes one 10 MHz clock for both ends and integer nanosecond timings.
package ddr2_bank_pkg;

  // ----------------------------------------------------------------
  // Command and state encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NOP = 3'b000,
    CMD_ACTIVATE = 3'b001,
    CMD_READ = 3'b010,
    CMD_WRITE = 3'b011,
    CMD_PRECHARGE = 3'b100
  } cmd_e;

  typedef enum logic [1:0] {
    BANK_IDLE = 2'b00,
    BANK_ACTIVE = 2'b01,
    BANK_AP_WAIT = 2'b10,
    BANK_PRECHARGING = 2'b11
  } bank_state_e;

  // ----------------------------------------------------------------
  // Sizes and mode settings after reset
  // ----------------------------------------------------------------
  localparam int NUM_BANKS = 4;
  localparam int CNT_W = 8;
  localparam int AL_DEF = 0;
  localparam int CL_DEF = 3;
  localparam int BL_DEF = 4;
  localparam int WR_DEF = 2;
  localparam int BL8_EXTRA = 2;
  localparam int MIN_RTP = 2;
  localparam int PREFETCH_GAP = 2;

  // ----------------------------------------------------------------
  // Analog times in ns and clock period
  // ----------------------------------------------------------------
  localparam int TCK_NS = 100;
  localparam int ROW_ACTIVE_TIME_NS = 45;
  localparam int TRP_NS = 15;
  localparam int READ_TO_PRECHARGE_TIME_NS = 8;
  localparam int TRC_NS = 60;

  // Least times, rounded up to whole clocks.
  localparam int ROW_ACTIVE_TIME_CYC = (ROW_ACTIVE_TIME_NS + TCK_NS - 1) / TCK_NS;
  localparam int TRP_CYC = (TRP_NS + TCK_NS - 1) / TCK_NS;
  localparam int RTP_CYC = (READ_TO_PRECHARGE_TIME_NS + TCK_NS - 1) / TCK_NS;
  localparam int TRC_CYC = (TRC_NS + TCK_NS - 1) / TCK_NS;
  localparam int RTPRP_CYC = (READ_TO_PRECHARGE_TIME_NS + TRP_NS + TCK_NS - 1) / TCK_NS;

endpackage : ddr2_bank_pkg

// [verilog/ddr2_cmd_if.sv]
// Command bus between the memory controller and the DRAM bank logic.
// Assumes both ends share mclk_i; the controller drives every signal.
`timescale 1ns/1ps
interface ddr2_cmd_if;
  import ddr2_bank_pkg::*;

  cmd_e cmd;
  logic bank_select_bit0;
  logic bank_select_bit1;
  logic auto_precharge_select_bit;

  modport ctrl (
    output cmd,
    output bank_select_bit0,
    output bank_select_bit1,
    output auto_precharge_select_bit
  );

  modport dram (
    input cmd,
    input bank_select_bit0,
    input bank_select_bit1,
    input auto_precharge_select_bit
  );
endinterface : ddr2_cmd_if

// [verilog/ddr2_bank_precharge_timing.sv]
// DRAM-side bank closing: explicit precharge decode and auto-precharge timing.
// Assumes the controller on the command bus keeps all spacing limits.
//
// Summary of operation
// - Precharge with select low closes one bank.
// - Precharge with select high closes all banks.
// - Controller spaces read to precharge correctly.
// - Controller waits row precharge before activate.
// - Controller waits row active before precharge.
// - Read-to-precharge measured from last prefetch.
// - Controller spaces write to precharge with recovery.
// - Open bank precharged before new row.
// - Select low on access leaves bank open.
// - Select high on access closes bank afterwards.
// - Read auto-precharge starts at latency plus half-burst.
// - Auto-precharge postponed until row active met.
// - Auto-precharge postponed until read-to-precharge met.
// - Pushed precharge period starts when read-to-precharge ends.
// - Controller waits read auto-precharge to activate.
// - Precharge at least two clocks after prefetch.
// - Controller reactivates after precharge and cycle time.
// - Write auto-precharge waits burst plus recovery.
// - Controller reactivates after write recovery, precharge, cycle.
// - Write auto-precharge waits for last data.
// - Lockout delays auto-precharge until restore done.
// - Each bank counts from latest precharge.
// - Read-to-precharge clocks rounded up from time.
`timescale 1ns/1ps
module ddr2_bank_precharge_timing
  import ddr2_bank_pkg::*;
#(
  parameter int AL = AL_DEF,
  parameter int BL = BL_DEF,
  parameter int WL = AL_DEF + CL_DEF - 1,
  parameter int WR = WR_DEF
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_i,
  // Command bus from the controller.
  ddr2_cmd_if.dram cmd_bus,
  // Per-bank status.
  output logic [NUM_BANKS-1:0] bank_open_o,
  output logic [NUM_BANKS-1:0] bank_idle_o,
  output logic [NUM_BANKS-1:0] auto_prech_start_o
);

  // ----------------------------------------------------------------
  // Derived cycle counts, loaded as count minus one
  // ----------------------------------------------------------------
  localparam int LAST_PF = AL + ((BL == 8) ? BL8_EXTRA : 0);
  localparam logic [CNT_W-1:0] LD_ROW_ACTIVE_TIME = CNT_W'(ROW_ACTIVE_TIME_CYC - 1);
  localparam logic [CNT_W-1:0] LD_TRP = CNT_W'(TRP_CYC - 1);
  localparam logic [CNT_W-1:0] LD_RD_NOM = CNT_W'(AL + BL / 2 - 1);
  localparam logic [CNT_W-1:0] LD_PF = CNT_W'(LAST_PF + PREFETCH_GAP - 1);
  localparam logic [CNT_W-1:0] LD_RTP = CNT_W'(LAST_PF + RTP_CYC - 1);
  localparam logic [CNT_W-1:0] LD_RTPRP = CNT_W'(LAST_PF + RTPRP_CYC - 1);
  localparam logic [CNT_W-1:0] LD_WR_NOM = CNT_W'(WL + BL / 2 + WR - 1);
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

  // ----------------------------------------------------------------
  // Command decode shared by all banks
  // ----------------------------------------------------------------
  logic [1:0] sel_bank;
  logic ap_bit;
  logic is_pre;
  logic is_act;
  logic is_rd;
  logic is_wr;

  // Bank address and command type taken from the bus each cycle.
  assign sel_bank = {cmd_bus.bank_select_bit1, cmd_bus.bank_select_bit0};
  assign ap_bit = cmd_bus.auto_precharge_select_bit;
  assign is_pre = (cmd_bus.cmd == CMD_PRECHARGE);
  assign is_act = (cmd_bus.cmd == CMD_ACTIVATE);
  assign is_rd = (cmd_bus.cmd == CMD_READ);
  assign is_wr = (cmd_bus.cmd == CMD_WRITE);

  // ----------------------------------------------------------------
  // Per-bank state and timers
  // ----------------------------------------------------------------
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    bank_state_e state;
    bank_state_e next_state;
    logic [CNT_W-1:0] ras_cnt;
    logic [CNT_W-1:0] rp_cnt;
    logic [CNT_W-1:0] nom_cnt;
    logic [CNT_W-1:0] pf_cnt;
    logic [CNT_W-1:0] rtp_cnt;
    logic [CNT_W-1:0] rtprp_cnt;
    logic hit;
    logic pre_hit;
    logic ap_rd;
    logic ap_wr;
    logic ap_start;
    logic [CNT_W-1:0] rp_after_rtp;

    assign hit = (sel_bank == 2'(b));
    assign pre_hit = is_pre && (ap_bit || hit);
    assign ap_rd = is_rd && hit && ap_bit && (state == BANK_ACTIVE);
    assign ap_wr = is_wr && hit && ap_bit && (state == BANK_ACTIVE);

    // nominal edge reached; prefetch gap; hold-offs.
    // lockout: no auto-precharge until row active time is met.
    assign ap_start = (state == BANK_AP_WAIT) && (nom_cnt == '0) && (pf_cnt == '0)
                      && (rtp_cnt == '0) && (ras_cnt == '0);

    // remaining precharge runs from where read-to-precharge ended.
    assign rp_after_rtp = (rtprp_cnt > ONE) ? (rtprp_cnt - ONE) : '0;

    // row active timer, restarted by each activate.
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        ras_cnt <= '0;
      end else if (is_act && hit) begin
        ras_cnt <= LD_ROW_ACTIVE_TIME;
      end else if (ras_cnt != '0) begin
        ras_cnt <= ras_cnt - ONE;
      end
    end

    // Auto-precharge wait timers, loaded by the access that engages it.
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        nom_cnt <= '0;
        pf_cnt <= '0;
        rtp_cnt <= '0;
        rtprp_cnt <= '0;
      end else if (ap_rd) begin
        // nominal edge at latency plus half-burst.
        nom_cnt <= LD_RD_NOM;
        pf_cnt <= LD_PF;
        rtp_cnt <= LD_RTP;
        rtprp_cnt <= LD_RTPRP;
      end else if (ap_wr) begin
        // burst end plus recovery; last data stored first.
        nom_cnt <= LD_WR_NOM;
        pf_cnt <= '0;
        rtp_cnt <= '0;
        rtprp_cnt <= '0;
      end else begin
        nom_cnt <= (nom_cnt != '0) ? nom_cnt - ONE : '0;
        pf_cnt <= (pf_cnt != '0) ? pf_cnt - ONE : '0;
        rtp_cnt <= (rtp_cnt != '0) ? rtp_cnt - ONE : '0;
        rtprp_cnt <= (rtprp_cnt != '0) ? rtprp_cnt - ONE : '0;
      end
    end

    // precharge period timer, restarted by the latest precharge.
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        rp_cnt <= '0;
      end else if (pre_hit) begin
        rp_cnt <= LD_TRP;
      end else if (ap_start) begin
        // take the later of a full period and the analog end.
        rp_cnt <= (rp_after_rtp > LD_TRP) ? rp_after_rtp : LD_TRP;
      end else if (rp_cnt != '0) begin
        rp_cnt <= rp_cnt - ONE;
      end
    end

    // Next bank state from the command and the timers.
    always_comb begin
      next_state = state;
      case (state)
        BANK_IDLE: begin
          if (is_act && hit) begin
            next_state = BANK_ACTIVE;
          end
        end
        BANK_ACTIVE: begin
          // plain access leaves the bank open.
          if (ap_rd || ap_wr) begin
            next_state = BANK_AP_WAIT;
          end
        end
        BANK_AP_WAIT: begin
          if (ap_start) begin
            next_state = BANK_PRECHARGING;
          end
        end
        BANK_PRECHARGING: begin
          // an activate is taken as soon as the period has ended.
          if (rp_cnt == '0) begin
            next_state = (is_act && hit) ? BANK_ACTIVE : BANK_IDLE;
          end
        end
        default: begin
          next_state = BANK_IDLE;
        end
      endcase
      // any precharge reaching the bank restarts its period.
      if (pre_hit) begin
        next_state = BANK_PRECHARGING;
      end
    end

    // State register and registered status outputs.
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        state <= BANK_IDLE;
        bank_open_o[b] <= 1'b0;
        bank_idle_o[b] <= 1'b1;
        auto_prech_start_o[b] <= 1'b0;
      end else begin
        state <= next_state;
        bank_open_o[b] <= (next_state == BANK_ACTIVE) || (next_state == BANK_AP_WAIT);
        bank_idle_o[b] <= (next_state == BANK_IDLE);
        auto_prech_start_o[b] <= ap_start && !pre_hit;
      end
    end
  end

endmodule : ddr2_bank_precharge_timing

// [verilog/ddr2_bank_ctrl.sv]
// Controller end: issues bank commands while keeping the spacing limits.
// Assumes a user holds each request until done_o pulses.
`timescale 1ns/1ps
module ddr2_bank_ctrl
  import ddr2_bank_pkg::*;
#(
  parameter int AL = AL_DEF,
  parameter int BL = BL_DEF,
  parameter int WL = AL_DEF + CL_DEF - 1,
  parameter int WR = WR_DEF
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_i,
  // User request.
  input wire logic req_valid_i,
  input wire cmd_e req_cmd_i,
  input wire logic [1:0] req_bank_i,
  input wire logic req_ap_i,
  output logic done_o,
  output logic err_o,
  // Command bus to the DRAM.
  ddr2_cmd_if.ctrl cmd_bus
);

  // ----------------------------------------------------------------
  // Spacing limits, loaded as count minus one
  // ----------------------------------------------------------------
  localparam int BL8_ADD = (BL == 8) ? BL8_EXTRA : 0;
  // clocks rounded up; read spacing with floor of two.
  localparam int RTP_USE = (RTP_CYC > MIN_RTP) ? RTP_CYC : MIN_RTP;
  localparam logic [CNT_W-1:0] LD_RD2PRE = CNT_W'(AL + BL / 2 + RTP_USE - 2 - 1);
  localparam logic [CNT_W-1:0] LD_WR2PRE = CNT_W'(WL + BL / 2 + WR - 1);
  localparam logic [CNT_W-1:0] LD_ROW_ACTIVE_TIME = CNT_W'(ROW_ACTIVE_TIME_CYC - 1);
  localparam logic [CNT_W-1:0] LD_TRP = CNT_W'(TRP_CYC - 1);
  localparam logic [CNT_W-1:0] LD_TRC = CNT_W'(TRC_CYC - 1);
  // last prefetch sits two clocks later for a burst of eight.
  // precharge period also runs from the start at latency plus half-burst.
  localparam int RDAP_TRP = AL + BL / 2 + TRP_CYC;
  localparam int RDAP_RTPRP = AL + BL8_ADD + RTPRP_CYC;
  localparam logic [CNT_W-1:0] LD_RDAP2ACT =
    CNT_W'(((RDAP_TRP > RDAP_RTPRP) ? RDAP_TRP : RDAP_RTPRP) - 1);
  localparam logic [CNT_W-1:0] LD_WRAP2ACT = CNT_W'(WL + BL / 2 + WR + TRP_CYC - 1);

  // Decrement to zero, then keep the later of that and a new limit.
  function automatic logic [CNT_W-1:0] stretch(input logic [CNT_W-1:0] cur,
                                               input logic ld,
                                               input logic [CNT_W-1:0] val);
    logic [CNT_W-1:0] dec;
    dec = (cur != '0) ? cur - CNT_W'(1) : '0;
    stretch = (ld && val > dec) ? val : dec;
  endfunction : stretch

  // ----------------------------------------------------------------
  // Command choice
  // ----------------------------------------------------------------
  logic [NUM_BANKS-1:0] open;
  logic [NUM_BANKS-1:0] pre_ok;
  logic [NUM_BANKS-1:0] act_ok;
  cmd_e next_cmd;
  logic [1:0] next_bank;
  logic next_ap;
  logic next_done;
  logic next_err;

  // At most one command in two cycles, so every command is followed by an empty cycle.
  always_comb begin
    next_cmd = CMD_NOP;
    next_bank = req_bank_i;
    next_ap = 1'b0;
    next_done = 1'b0;
    next_err = 1'b0;
    if (req_valid_i && !done_o && (cmd_bus.cmd == CMD_NOP)) begin
      case (req_cmd_i)
        CMD_ACTIVATE: begin
          if (open[req_bank_i]) begin
            if (pre_ok[req_bank_i]) begin
              next_cmd = CMD_PRECHARGE;
            end
          end else if (act_ok[req_bank_i]) begin
            next_cmd = CMD_ACTIVATE;
            next_done = 1'b1;
          end
        end
        CMD_READ, CMD_WRITE: begin
          if (!open[req_bank_i]) begin
            next_done = 1'b1;
            next_err = 1'b1;
          end else begin
            next_cmd = req_cmd_i;
            next_ap = req_ap_i;
            next_done = 1'b1;
          end
        end
        CMD_PRECHARGE: begin
          // precharge only after the bank limits.
          if (req_ap_i ? (&pre_ok) : pre_ok[req_bank_i]) begin
            next_cmd = CMD_PRECHARGE;
            next_ap = req_ap_i;
            next_done = 1'b1;
          end
        end
        default: begin
          next_done = 1'b1;
          next_err = 1'b1;
        end
      endcase
    end
  end

  // Registered command bus and user answer.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cmd_bus.cmd <= CMD_NOP;
      cmd_bus.bank_select_bit0 <= 1'b0;
      cmd_bus.bank_select_bit1 <= 1'b0;
      cmd_bus.auto_precharge_select_bit <= 1'b0;
      done_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      cmd_bus.cmd <= next_cmd;
      cmd_bus.bank_select_bit0 <= next_bank[0];
      cmd_bus.bank_select_bit1 <= next_bank[1];
      cmd_bus.auto_precharge_select_bit <= next_ap;
      done_o <= next_done;
      err_o <= next_err;
    end
  end

  // ----------------------------------------------------------------
  // Per-bank spacing timers
  // ----------------------------------------------------------------
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    logic [CNT_W-1:0] pre_cnt;
    logic [CNT_W-1:0] act_cnt;
    logic hit;
    logic act;
    logic rd;
    logic wr;
    logic pre;

    assign hit = (next_bank == 2'(b));
    assign act = (next_cmd == CMD_ACTIVATE) && hit;
    assign rd = (next_cmd == CMD_READ) && hit;
    assign wr = (next_cmd == CMD_WRITE) && hit;
    assign pre = (next_cmd == CMD_PRECHARGE) && (next_ap || hit);
    assign pre_ok[b] = (pre_cnt == '0);
    assign act_ok[b] = (act_cnt == '0);

    // row active, read and write limits before precharge.
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        pre_cnt <= '0;
      end else begin
        pre_cnt <= stretch(pre_cnt, act || rd || wr,
                           act ? LD_ROW_ACTIVE_TIME : (rd ? LD_RD2PRE : LD_WR2PRE));
      end
    end

    // row precharge, auto-precharge and cycle limits.
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        act_cnt <= '0;
      end else if (act) begin
        act_cnt <= stretch(act_cnt, 1'b1, LD_TRC);
      end else if (pre) begin
        act_cnt <= stretch(act_cnt, 1'b1, LD_TRP);
      end else begin
        act_cnt <= stretch(act_cnt, next_ap && (rd || wr), rd ? LD_RDAP2ACT : LD_WRAP2ACT);
      end
    end

    // Open-row tracking; an auto-precharge access closes the row.
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        open[b] <= 1'b0;
      end else if (act) begin
        open[b] <= 1'b1;
      end else if (pre || ((rd || wr) && next_ap)) begin
        open[b] <= 1'b0;
      end
    end
  end

endmodule : ddr2_bank_ctrl

// [sim/ddr2_bank_props.sv]
// Checker for the bank command bus and the DRAM bank status outputs.
// Assumes default mode settings on both ends: AL 0, BL 4, WL 2, WR 2, one-clock limits.
`timescale 1ns/1ps
module ddr2_bank_props
  import ddr2_bank_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_i,
  // Command bus.
  input wire cmd_e cmd,
  input wire logic bank_select_bit0,
  input wire logic bank_select_bit1,
  input wire logic auto_precharge_select_bit,
  // Bank status and user answers.
  input wire logic [NUM_BANKS-1:0] bank_open_o,
  input wire logic [NUM_BANKS-1:0] bank_idle_o,
  input wire logic [NUM_BANKS-1:0] auto_prech_start_o,
  input wire logic done_o,
  input wire logic err_o
);
  logic [1:0] sel;
  logic ap;

  // Bank number and select bit gathered for short properties.
  assign sel = {bank_select_bit1, bank_select_bit0};
  assign ap = auto_precharge_select_bit;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // Whole-bus relations
  // ----------------------------------------------------------------
  property p_pre_one;
    cmd == CMD_PRECHARGE && !ap |=> !bank_open_o[$past(sel)];
  endproperty
  a_pre_one: assert property (p_pre_one) else $error("single precharge left bank open");
  property p_pre_all;
    cmd == CMD_PRECHARGE && ap |=> bank_open_o == 4'h0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");
  property p_keep_open;
    (cmd == CMD_READ || cmd == CMD_WRITE) && !ap && bank_open_o[sel] |=> bank_open_o[$past(sel)];
  endproperty
  a_keep_open: assert property (p_keep_open) else $error("plain access closed bank");
  property p_space;
    cmd != CMD_NOP |=> cmd == CMD_NOP;
  endproperty
  a_space: assert property (p_space) else $error("commands closer than two cycles");
  property p_done_cmd;
    done_o && !err_o |-> cmd != CMD_NOP;
  endproperty
  a_done_cmd: assert property (p_done_cmd) else $error("done without command");
  property p_err_nop;
    err_o |-> done_o && cmd == CMD_NOP;
  endproperty
  a_err_nop: assert property (p_err_nop) else $error("refused request issued command");

  // ----------------------------------------------------------------
  // Per-bank timing
  // ----------------------------------------------------------------
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    sequence s_rd_ap_wait;
      (!auto_prech_start_o[b]) [*2] ##1 auto_prech_start_o[b];
    endsequence
    sequence s_wr_ap_wait;
      (!auto_prech_start_o[b]) [*6] ##1 auto_prech_start_o[b];
    endsequence
    property p_rd_ap;
      cmd == CMD_READ && ap && sel == b && bank_open_o[b] |-> ##1 s_rd_ap_wait;
    endproperty
    a_rd_ap: assert property (p_rd_ap) else $error("read auto-precharge start off");
    property p_wr_ap;
      cmd == CMD_WRITE && ap && sel == b && bank_open_o[b] |-> ##1 s_wr_ap_wait;
    endproperty
    a_wr_ap: assert property (p_wr_ap) else $error("write auto-precharge start off");
    property p_ap_close;
      $rose(auto_prech_start_o[b]) |-> !bank_open_o[b];
    endproperty
    a_ap_close: assert property (p_ap_close) else $error("bank open after auto start");
    property p_pre_idle;
      cmd == CMD_PRECHARGE && (ap || sel == b) |=> !bank_open_o[b] ##[0:2] bank_idle_o[b];
    endproperty
    a_pre_idle: assert property (p_pre_idle) else $error("precharge period not ended");
    property p_wr_pre;
      cmd == CMD_WRITE && sel == b |=> (!(cmd == CMD_PRECHARGE && (ap || sel == b))) [*5];
    endproperty
    a_wr_pre: assert property (p_wr_pre) else $error("precharge too soon after write");
    property p_wr_act;
      cmd == CMD_WRITE && ap && sel == b |=> (!(cmd == CMD_ACTIVATE && sel == b)) [*6];
    endproperty
    a_wr_act: assert property (p_wr_act) else $error("activate too soon after write");
  end
endmodule : ddr2_bank_props

// [sim/tb.sv]
// Testbench joining the controller end and the DRAM end over the command interface.
// Assumes default mode parameters; the bench models open banks and expected answers.
`timescale 1ns/1ps
module tb
  import ddr2_bank_pkg::*;
;
  typedef struct packed {cmd_e cmd; logic [1:0] bank; logic ap; logic err;} note_s;

  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  cmd_e req_cmd_i = CMD_NOP;
  logic [1:0] req_bank_i = 2'h0;
  logic req_ap_i = 1'b0;
  logic done_o;
  logic err_o;
  logic [3:0] bank_open_o;
  logic [3:0] bank_idle_o;
  logic [3:0] auto_prech_start_o;
  logic [3:0] exp_open;
  int failures = 0;
  int compares = 0;
  note_s q_done[$];
  logic [3:0] q_ap[$];

  ddr2_cmd_if ddr2_cmd_if_inst ();
  ddr2_bank_ctrl ddr2_bank_ctrl_inst (.mclk_i(mclk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
    .req_cmd_i(req_cmd_i), .req_bank_i(req_bank_i), .req_ap_i(req_ap_i), .done_o(done_o),
    .err_o(err_o), .cmd_bus(ddr2_cmd_if_inst));
  ddr2_bank_precharge_timing ddr2_bank_precharge_timing_inst (.mclk_i(mclk_i), .rst_i(rst_i),
    .cmd_bus(ddr2_cmd_if_inst), .bank_open_o(bank_open_o), .bank_idle_o(bank_idle_o),
    .auto_prech_start_o(auto_prech_start_o));
  ddr2_bank_props ddr2_bank_props_inst (.mclk_i(mclk_i), .rst_i(rst_i),
    .cmd(ddr2_cmd_if_inst.cmd), .bank_select_bit0(ddr2_cmd_if_inst.bank_select_bit0),
    .bank_select_bit1(ddr2_cmd_if_inst.bank_select_bit1),
    .auto_precharge_select_bit(ddr2_cmd_if_inst.auto_precharge_select_bit),
    .bank_open_o(bank_open_o), .bank_idle_o(bank_idle_o),
    .auto_prech_start_o(auto_prech_start_o), .done_o(done_o), .err_o(err_o));

  // Free-running 10 MHz clock.
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk_vec(string name, logic [3:0] exp, logic [3:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk_vec

  task automatic chk_note(note_s exp, note_s got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected command bus: expected %h, seen %h", exp, got);
    end
  endtask : chk_note

  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  task automatic do_reset();
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    exp_open = 4'h0;
    @(posedge mclk_i);
    @(posedge mclk_i);
    chk_vec("bank_open_o", 4'h0, bank_open_o);
    chk_vec("bank_idle_o", 4'hF, bank_idle_o);
    $display("test reset finished");
  endtask : do_reset

  // Notes the expected answer, makes one request, then checks the settled bank state.
  task automatic send(cmd_e c, logic [1:0] b, logic ap);
    note_s n;
    int k;
    n.err = (c == CMD_NOP) || ((c == CMD_READ || c == CMD_WRITE) && !exp_open[b]);
    n.cmd = n.err ? CMD_NOP : c;
    n.bank = b;
    // An activate never carries the select bit onto the bus.
    n.ap = ap && (c != CMD_ACTIVATE);
    q_done.push_back(n);
    if (!n.err && n.ap && c != CMD_PRECHARGE) q_ap.push_back(4'h1 << b);
    @(posedge mclk_i);
    req_valid_i <= 1'b1;
    req_cmd_i <= c;
    req_bank_i <= b;
    req_ap_i <= ap;
    for (k = 0; k < 60 && done_o !== 1'b1; k++) @(posedge mclk_i);
    req_valid_i <= 1'b0;
    if (k == 60) failures++;
    if (c == CMD_ACTIVATE) exp_open[b] = 1'b1;
    if (!n.err && n.ap && c != CMD_PRECHARGE) exp_open[b] = 1'b0;
    if (c == CMD_PRECHARGE) exp_open = ap ? 4'h0 : exp_open & ~(4'h1 << b);
    repeat (10) @(posedge mclk_i);
    chk_vec("bank_open_o", exp_open, bank_open_o);
    chk_vec("bank_idle_o", ~exp_open, bank_idle_o);
  endtask : send

  // Takes the oldest note whenever the controller answers or a bank starts auto-precharge.
  always @(posedge mclk_i) begin : watch
    note_s e;
    note_s g;
    if (!rst_i && done_o === 1'b1) begin
      e = q_done.pop_front();
      g.cmd = ddr2_cmd_if_inst.cmd;
      g.bank = {ddr2_cmd_if_inst.bank_select_bit1, ddr2_cmd_if_inst.bank_select_bit0};
      g.ap = e.err ? e.ap : ddr2_cmd_if_inst.auto_precharge_select_bit;
      g.err = err_o;
      if (e.err || (e.cmd == CMD_PRECHARGE && e.ap)) g.bank = e.bank;
      chk_note(e, g);
    end
    if (!rst_i && auto_prech_start_o !== 4'h0) begin
      chk_vec("auto_prech_start_o", q_ap.pop_front(), auto_prech_start_o);
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'ha3f9cbb0));
    do_reset();
    for (int b = 0; b < 4; b++) send(CMD_ACTIVATE, 2'(b), 1'b0);
    for (int b = 0; b < 4; b++) begin
      send(CMD_PRECHARGE, 2'(b), 1'b0);
      send(CMD_ACTIVATE, 2'(b), 1'b0);
    end
    send(CMD_PRECHARGE, 2'($urandom_range(0, 3)), 1'b1);
    $display("test explicit precharge finished");
    send(CMD_ACTIVATE, 2'h2, 1'b0);
    send(CMD_READ, 2'h2, 1'b0);
    send(CMD_WRITE, 2'h2, 1'b0);
    send(CMD_READ, 2'h2, 1'b1);
    send(CMD_ACTIVATE, 2'h1, 1'b0);
    send(CMD_WRITE, 2'h1, 1'b1);
    send(CMD_ACTIVATE, 2'h1, 1'b0);
    send(CMD_ACTIVATE, 2'h1, 1'b0);
    $display("test auto precharge finished");
    send(CMD_READ, 2'h3, 1'b1);
    send(CMD_NOP, 2'h0, 1'b0);
    for (int i = 0; i < 24; i++) begin
      send(cmd_e'($urandom_range(0, 4)), 2'($urandom_range(0, 3)), 1'($urandom_range(0, 1)));
    end
    $display("test random mix finished");
    do_reset();
    chk_vec("pending notes", 4'h0, 4'(q_ap.size() + q_done.size()));
    close_out();
  end

  // Cuts a hang short at 10000 cycles, well past the expected few hundred cycles.
  initial begin
    #1000000;
    failures++;
    $display("watchdog expired");
    close_out();
  end
endmodule : tb
